// file: hw/gpm_mapper.sv
// Purpose: Map character codes and icon RAM onto pixel and segment data
// Assumes: Row counter and character requests come from core_clk logic
// Notes:   Pattern ROM is writable so software can load its contents
//
// Summary of operation
// - Code bit 3 ignored for user RAM
// - User RAM one bit lights pixel
// - Bit 7 blinks set low five/six bits
// - Bit 6 blinks edge column pixel
// - Five-dot icons: five segments per byte
// - Six-dot icons: six segments per byte
// - Icons output on first, 17th/33rd rows
// - Segments past sixty go to extension
// - Segment sequence wraps after 80/96
// - Icon bit 7 blinks set bits
// - Icon bit 6 blinks edge segment
// - Five-dot icons ignore bit 5
// - Icon one bit turns segment on
// - ROM address code, zero, line
// - ROM low five bits are pixels
// - ROM holds eighth line too
// - ROM zeros at user RAM codes; here ROM loads at those codes keep the values given
// - Unprogrammed ROM shows all dots lit; here the ROM is given no initial contents
// - Upper nibble zero selects user RAM
// - User RAM address code, line; cursor OR
//
// The register addresses and the address-and-strobe port were left to the implementer.
`default_nettype none
module gpm_mapper
  import gpm_pkg::*;
#(
  parameter int BLINK_CYCLES = GPM_BLINK_CYCLES
) (
  // Clock and reset
  input  wire  logic         core_clk,
  input  wire  logic         rst,
  // Register port
  input  wire  logic [7:0]   reg_addr,
  input  wire  logic [31:0]  reg_wdata,
  input  wire  logic         reg_wr,
  input  wire  logic         reg_rd,
  output logic [31:0]        reg_rdata,
  // Character pixel lookup
  input  wire  gpm_pix_req_t pix_req,
  output gpm_pix_rsp_t       pix_rsp,
  // Common row counter
  input  wire  logic [5:0]   row_count,
  // Segment outputs
  output logic [59:0]        seg_out,
  output logic               seg_out_valid,
  output logic [35:0]        ext_seg_out,
  output logic [6:0]         seg_scan_pos
);

  typedef struct packed {
    logic [31:0]  rdata;
    logic [31:0]  ctrl;
    logic [5:0]   upr_addr;
    logic [3:0]   isr_addr;
    logic [11:0]  rom_addr;
    logic [31:0]  blink_cnt;
    logic         blink_phase;
    gpm_pix_rsp_t pix;
    logic [59:0]  seg;
    logic         seg_valid;
    logic [35:0]  ext;
    logic [6:0]   scan;
  } gpm_state_t;

  gpm_state_t state_reg;
  gpm_state_t state_next;

  // Memories
  logic [7:0] user_pattern_ram [0:63];
  logic [7:0] icon_segment_ram [0:15];
  logic [7:0] fixed_pattern_rom [0:4095];

  logic       font_width_select;
  logic       pattern_blink_enable;
  gpm_lines_t line_mode;

  assign pattern_blink_enable = state_reg.ctrl[GPM_CTRL_BLINK_BIT];
  assign font_width_select    = state_reg.ctrl[GPM_CTRL_FONT_BIT];
  assign line_mode = gpm_lines_t'(state_reg.ctrl[GPM_CTRL_LINES_LO +: 2]);

  // Apply blink control to a pattern byte; returns shown bits
  function automatic logic [5:0] apply_blink(
    input logic [7:0] data,
    input logic       wide,
    input logic       en,
    input logic       hide
  );
    logic [5:0] bits;
    logic [5:0] mask;
    bits = wide ? data[5:0] : {1'b0, data[4:0]};
    mask = 6'h00;
    if (en && data[GPM_SET_BITS_POS]) begin
      mask = bits;
    end
    if (en && data[GPM_EDGE_COL_POS]) begin
      mask = mask | (wide ? 6'h20 : 6'h10);
    end
    apply_blink = hide ? (bits & ~mask) : bits;
  endfunction : apply_blink

  // User pattern RAM address from code and line
  function automatic logic [5:0] upr_index(
    input logic [7:0] code,
    input logic [2:0] line
  );
    upr_index = {code[2:0], line};
  endfunction : upr_index

  // Fixed pattern ROM address from code and line
  function automatic logic [11:0] rom_index(
    input logic [7:0] code,
    input logic [2:0] line
  );
    rom_index = {code, 1'b0, line};
  endfunction : rom_index

  logic       icon_row;
  logic [5:0] upr_bits;
  logic [5:0] rom_bits;
  logic [5:0] pix_bits;
  logic [5:0] upr_sel_addr;
  logic [11:0] rom_sel_addr;
  logic [95:0] icon_map;
  logic [95:0] icon_rot;
  logic [5:0]  ibits;

  always_comb begin
    upr_sel_addr = upr_index(pix_req.code, pix_req.line);
    rom_sel_addr = rom_index(pix_req.code, pix_req.line);
    upr_bits = apply_blink(user_pattern_ram[upr_sel_addr],
                           font_width_select, pattern_blink_enable,
                           state_reg.blink_phase);
    rom_bits = {1'b0, fixed_pattern_rom[rom_sel_addr][4:0]};
    if (pix_req.code[7:4] == 4'h0) begin
      pix_bits = upr_bits;
    end else begin
      pix_bits = rom_bits;
    end
    if (pix_req.line == 3'h7 && pix_req.cursor) begin
      pix_bits = pix_bits | (font_width_select ? 6'h3f : 6'h1f);
    end
  end

  // Icon segment map, segment one at index 0
  always_comb begin
    icon_map = '0;
    for (int a = 0; a < 16; a++) begin
      ibits = apply_blink(icon_segment_ram[a], font_width_select,
                          pattern_blink_enable, state_reg.blink_phase);
      for (int b = 0; b < 6; b++) begin
        if (font_width_select) begin
          icon_map[a * 6 + b] = ibits[5 - b];
        end else if (b < 5) begin
          icon_map[a * 5 + b] = ibits[4 - b];
        end
      end
    end
  end

  // Rotate so the scan position leads the output
  always_comb begin
    icon_rot = '0;
    for (int i = 0; i < 96; i++) begin
      if (font_width_select) begin
        icon_rot[i] = icon_map[(32'(state_reg.scan) + i) % 96];
      end else if (i < 80) begin
        icon_rot[i] = icon_map[(32'(state_reg.scan) + i) % 80];
      end
    end
  end

  always_comb begin
    case (line_mode)
      GPM_LINES_1: begin
        icon_row = (row_count == GPM_ROW_FIRST) ||
                   (row_count == GPM_ROW_17);
      end
      GPM_LINES_2, GPM_LINES_4: begin
        icon_row = (row_count == GPM_ROW_FIRST) ||
                   (row_count == GPM_ROW_33);
      end
      default: begin
        icon_row = 1'b0;
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    state_next.rdata = 32'h0000_0000;
    // Blink divider
    if (state_reg.blink_cnt >= 32'(BLINK_CYCLES - 1)) begin
      state_next.blink_cnt = 32'h0000_0000;
      state_next.blink_phase = ~state_reg.blink_phase;
    end else begin
      state_next.blink_cnt = state_reg.blink_cnt + 32'h0000_0001;
    end
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        GPM_OFF_CTRL:     state_next.ctrl = reg_wdata;
        GPM_OFF_UPR_ADDR: state_next.upr_addr = reg_wdata[5:0];
        GPM_OFF_ISR_ADDR: state_next.isr_addr = reg_wdata[3:0];
        GPM_OFF_ROM_ADDR: state_next.rom_addr = reg_wdata[11:0];
        GPM_OFF_UPR_DATA: state_next.upr_addr = state_reg.upr_addr + 6'h01;
        GPM_OFF_ISR_DATA: state_next.isr_addr = state_reg.isr_addr + 4'h1;
        GPM_OFF_ROM_DATA: state_next.rom_addr = state_reg.rom_addr + 12'h001;
        default: begin
        end
      endcase
    end
    // Register reads
    if (reg_rd) begin
      case (reg_addr)
        GPM_OFF_CTRL:     state_next.rdata = state_reg.ctrl;
        GPM_OFF_STATUS:   state_next.rdata = {24'h0, state_reg.scan,
                                              state_reg.blink_phase};
        GPM_OFF_UPR_ADDR: state_next.rdata = {26'h0, state_reg.upr_addr};
        GPM_OFF_UPR_DATA: state_next.rdata =
          {24'h0, user_pattern_ram[state_reg.upr_addr]};
        GPM_OFF_ISR_ADDR: state_next.rdata = {28'h0, state_reg.isr_addr};
        GPM_OFF_ISR_DATA: state_next.rdata =
          {24'h0, icon_segment_ram[state_reg.isr_addr]};
        GPM_OFF_ROM_ADDR: state_next.rdata = {20'h0, state_reg.rom_addr};
        GPM_OFF_ROM_DATA: state_next.rdata =
          {24'h0, fixed_pattern_rom[state_reg.rom_addr]};
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
    // Pixel lookup result
    state_next.pix.valid    = pix_req.req;
    state_next.pix.row_bits = pix_req.req ? pix_bits : 6'h00;
    // Segment outputs on icon rows
    state_next.seg_valid = icon_row;
    if (icon_row) begin
      state_next.seg = icon_rot[59:0];
      state_next.ext = icon_rot[95:60];
      if (font_width_select) begin
        state_next.scan = (state_reg.scan >= GPM_SEG_END6 - 7'h01) ?
          7'h00 : state_reg.scan + 7'h01;
      end else begin
        state_next.scan = (state_reg.scan >= GPM_SEG_END5 - 7'h01) ?
          7'h00 : state_reg.scan + 7'h01;
      end
    end else begin
      state_next.seg = '0;
      state_next.ext = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg      <= '0;
      state_reg.ctrl <= GPM_CTRL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Memory writes; ROM loads keep unused bits and user codes as given
  always_ff @(posedge core_clk) begin
    if (reg_wr && reg_addr == GPM_OFF_UPR_DATA) begin
      user_pattern_ram[state_reg.upr_addr] <= reg_wdata[7:0];
    end
    if (reg_wr && reg_addr == GPM_OFF_ISR_DATA) begin
      icon_segment_ram[state_reg.isr_addr] <= reg_wdata[7:0];
    end
    if (reg_wr && reg_addr == GPM_OFF_ROM_DATA) begin
      fixed_pattern_rom[state_reg.rom_addr] <= reg_wdata[7:0];
    end
  end

  assign reg_rdata     = state_reg.rdata;
  assign pix_rsp       = state_reg.pix;
  assign seg_out       = state_reg.seg;
  assign seg_out_valid = state_reg.seg_valid;
  assign ext_seg_out   = state_reg.ext;
  assign seg_scan_pos  = state_reg.scan;

endmodule : gpm_mapper
`default_nettype wire

// file: pkg/gpm_pkg.sv
// Purpose: Shared constants and carriers for the glyph and icon mapper
// Assumes: 100 MHz core clock
// Notes:   Register offsets are byte addresses, four apart, on the plain register port
`default_nettype none
package gpm_pkg;
  // Register map
  localparam logic [7:0] GPM_OFF_CTRL     = 8'h00;
  localparam logic [7:0] GPM_OFF_STATUS   = 8'h04;
  localparam logic [7:0] GPM_OFF_UPR_ADDR = 8'h08;
  localparam logic [7:0] GPM_OFF_UPR_DATA = 8'h0c;
  localparam logic [7:0] GPM_OFF_ISR_ADDR = 8'h10;
  localparam logic [7:0] GPM_OFF_ISR_DATA = 8'h14;
  localparam logic [7:0] GPM_OFF_ROM_ADDR = 8'h18;
  localparam logic [7:0] GPM_OFF_ROM_DATA = 8'h1c;
  // Control field positions
  localparam int GPM_CTRL_BLINK_BIT = 0;
  localparam int GPM_CTRL_FONT_BIT  = 1;
  localparam int GPM_CTRL_LINES_LO  = 2;
  localparam logic [31:0] GPM_CTRL_RESET = 32'h0000_0000;
  // Pattern byte fields
  localparam int GPM_SET_BITS_POS  = 7;
  localparam int GPM_EDGE_COL_POS  = 6;
  localparam int GPM_CODE_ALIAS    = 3;
  // Common rows carrying icon data (0-based)
  localparam logic [5:0] GPM_ROW_FIRST = 6'h00;
  localparam logic [5:0] GPM_ROW_17    = 6'h10;
  localparam logic [5:0] GPM_ROW_33    = 6'h20;
  // Segment counts
  localparam logic [6:0] GPM_SEG_LOCAL = 7'h3c;
  localparam logic [6:0] GPM_SEG_END5  = 7'h50;
  localparam logic [6:0] GPM_SEG_END6  = 7'h60;
  // Blink timing
  localparam int GPM_CLK_MHZ      = 100;
  localparam int GPM_BLINK_HALF_MS = 400;
  localparam int GPM_BLINK_CYCLES = GPM_BLINK_HALF_MS * 1000 * GPM_CLK_MHZ;
  // Line mode encodings
  typedef enum logic [1:0] {
    GPM_LINES_1 = 2'b00,
    GPM_LINES_2 = 2'b01,
    GPM_LINES_4 = 2'b10
  } gpm_lines_t;
  // Pixel request carrier
  typedef struct packed {
    logic       req;
    logic [7:0] code;
    logic [2:0] line;
    logic       cursor;
  } gpm_pix_req_t;
  typedef struct packed {
    logic       valid;
    logic [5:0] row_bits;
  } gpm_pix_rsp_t;
endpackage : gpm_pkg
`default_nettype wire

// file: testbench/gpm_mapper_properties.sv
// Purpose: Port-level properties of the glyph and icon mapper
// Assumes: Bound to every mapper instance
// Notes:   Tracks font width from control writes
`default_nettype none
module gpm_mapper_chk
  import gpm_pkg::*;
#(
  parameter int BLINK_CYCLES = GPM_BLINK_CYCLES
) (
  // Clock, reset and control writes
  input wire logic         core_clk,
  input wire logic         rst,
  input wire logic [7:0]   reg_addr,
  input wire logic [31:0]  reg_wdata,
  input wire logic         reg_wr,
  // Lookup and segment side
  input wire gpm_pix_req_t pix_req,
  input wire gpm_pix_rsp_t pix_rsp,
  input wire logic [5:0]   row_count,
  input wire logic [59:0]  seg_out,
  input wire logic         seg_out_valid,
  input wire logic [6:0]   seg_scan_pos
);
  logic wide_reg;
  logic icon_row;
  assign icon_row = row_count inside {GPM_ROW_FIRST, GPM_ROW_17, GPM_ROW_33};
  always_ff @(posedge core_clk) begin
    if (rst) wide_reg <= 1'b0;
    else if (reg_wr && reg_addr == GPM_OFF_CTRL)
      wide_reg <= reg_wdata[GPM_CTRL_FONT_BIT];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_rsp; pix_req.req |=> pix_rsp.valid; endproperty
  a_rsp: assert property (p_rsp) else $error("no lookup response");
  property p_norsp; !pix_req.req |=> !pix_rsp.valid; endproperty
  a_norsp: assert property (p_norsp) else $error("stray response");
  property p_rsp5; pix_rsp.valid && !wide_reg |-> !pix_rsp.row_bits[5];
  endproperty
  a_rsp5: assert property (p_rsp5) else $error("sixth dot in 5 wide");
  property p_seg_valid; row_count == GPM_ROW_FIRST |=> seg_out_valid;
  endproperty
  a_seg_valid: assert property (p_seg_valid) else $error("no icons");
  property p_seg_idle; !icon_row |=> !seg_out_valid && seg_out == '0;
  endproperty
  a_seg_idle: assert property (p_seg_idle) else $error("icons off row");
  property p_icon_cause; seg_out_valid |-> $past(icon_row); endproperty
  a_icon_cause: assert property (p_icon_cause) else $error("bad row");
  property p_scan_adv; row_count == GPM_ROW_FIRST |=>
    seg_scan_pos == 7'($past(seg_scan_pos) + 7'h01) || seg_scan_pos == 7'h00;
  endproperty
  a_scan_adv: assert property (p_scan_adv) else $error("scan step");
  property p_scan5; !wide_reg |-> seg_scan_pos < GPM_SEG_END5; endproperty
  a_scan5: assert property (p_scan5) else $error("scan past 80");
  c_req: cover property (pix_req.req);
  c_icon: cover property (seg_out_valid);
  c_row33: cover property (row_count == GPM_ROW_33 ##1 seg_out_valid);
endmodule : gpm_mapper_chk
bind gpm_mapper gpm_mapper_chk #(.BLINK_CYCLES(BLINK_CYCLES)) u_chk (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .pix_req(pix_req),
  .pix_rsp(pix_rsp), .row_count(row_count), .seg_out(seg_out),
  .seg_out_valid(seg_out_valid), .seg_scan_pos(seg_scan_pos));
`default_nettype wire

// file: testbench/gpm_testbench.sv
// Purpose: Self-checking bench for the glyph and icon mapper
// Assumes: Blink on only for the blink checks, divider shortened
// Notes:   Fixed seed keeps random data repeatable
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench
  import gpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         core_clk, rst, reg_wr, reg_rd, seg_out_valid;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata;
  gpm_pix_req_t pix_req;
  gpm_pix_rsp_t pix_rsp;
  logic [5:0]   row_count;
  logic [59:0]  seg_out;
  logic [35:0]  ext_seg_out;
  logic [6:0]   seg_scan_pos;
  logic [7:0]   upr [64];
  logic [7:0]   isr [16];
  int           bad_count, checks;
  int           cyc;
  localparam int TB_BLINK = 4;
  gpm_mapper #(.BLINK_CYCLES(TB_BLINK)) DUT (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pix_req(pix_req), .pix_rsp(pix_rsp),
    .row_count(row_count), .seg_out(seg_out),
    .seg_out_valid(seg_out_valid), .ext_seg_out(ext_seg_out),
    .seg_scan_pos(seg_scan_pos));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Edges since reset release, mirrors the blink divider period
  always_ff @(posedge core_clk) cyc <= rst ? 0 : cyc + 1;
  // Blink phase that the last sampled request saw; 1 hides
  function automatic logic hid();
    return ((cyc - 1) / TB_BLINK) % 2 == 1;
  endfunction : hid
  function automatic logic [5:0] blink_bits(input logic [7:0] d,
                                            input logic w, input logic h);
    logic [5:0] s;
    logic [5:0] m;
    s = w ? d[5:0] : {1'b0, d[4:0]};
    m = d[7] ? s : 6'h00;
    if (d[6]) m = m | (w ? 6'h20 : 6'h10);
    return h ? (s & ~m) : s;
  endfunction : blink_bits
  task automatic look_blink(input logic [7:0] c, input logic [2:0] l,
                            input logic [7:0] d, input logic w);
    @(posedge core_clk);
    pix_req <= '{1'b1, c, l, 1'b0};
    @(posedge core_clk);
    pix_req.req <= 1'b0;
    #1 `CHK(pix_rsp.row_bits, blink_bits(d, w, hid()))
  endtask : look_blink
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rd
  task automatic look(input logic [7:0] c, input logic [2:0] l,
                      input logic cu, input logic [5:0] e);
    @(posedge core_clk);
    pix_req <= '{1'b1, c, l, cu};
    @(posedge core_clk);
    pix_req.req <= 1'b0;
    #1 `CHK({pix_rsp.valid, pix_rsp.row_bits}, {1'b1, e})
  endtask : look
  // One cycle on a common row, then back to a plain row
  task automatic rowp(input logic [5:0] r);
    @(posedge core_clk);
    row_count <= r;
    @(posedge core_clk);
    row_count <= 6'h05;
    #1;
  endtask : rowp
  function automatic logic [95:0] icon_exp(input logic w, input logic h);
    logic [95:0] e;
    logic [5:0]  q;
    e = '0;
    for (int a = 0; a < 16; a++) begin
      q = blink_bits(isr[a], w, h);
      for (int k = 0; k < 6; k++)
        if (w) e[6*a+k] = q[5-k];
        else if (k < 5) e[5*a+k] = q[4-k];
    end
    return e;
  endfunction : icon_exp
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    #1000000;
    bad_count++;
    $display("[FAIL] %0t run timed out", $time);
    end_sim();
  end
  initial begin
    logic [7:0] c, b;
    logic [2:0] l;
    logic cu;
    logic [5:0] v;
    logic [95:0] x;
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0;
    reg_wdata = '0; pix_req = '0; row_count = 6'h05;
    bad_count = 0; checks = 0;
    void'($urandom(45559));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rd(GPM_OFF_CTRL, GPM_CTRL_RESET);
    rd(8'h20, 32'h0);
    $display("registers done");
    wr(GPM_OFF_ISR_ADDR, 32'h0);
    for (int a = 0; a < 16; a++) begin
      isr[a] = 8'($urandom);
      wr(GPM_OFF_ISR_DATA, {24'h0, isr[a]});
    end
    rowp(GPM_ROW_FIRST);
    x = icon_exp(1'b0, 1'b0);
    `CHK({ext_seg_out[19:0], seg_out}, x[79:0])
    for (int m = 0; m < 3; m++) begin
      wr(GPM_OFF_CTRL, 32'(m << 2));
      rowp(GPM_ROW_17);
      `CHK(seg_out_valid, 1'(m == 0))
      rowp(GPM_ROW_33);
      `CHK(seg_out_valid, 1'(m != 0))
    end
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    wr(GPM_OFF_CTRL, 32'h2);
    rowp(GPM_ROW_FIRST);
    `CHK({ext_seg_out, seg_out}, icon_exp(1'b1, 1'b0))
    // Blink on, scan now one step on: rotated by one segment
    wr(GPM_OFF_CTRL, 32'h3);
    rowp(GPM_ROW_FIRST);
    x = icon_exp(1'b1, hid());
    `CHK({ext_seg_out, seg_out}, {x[0], x[95:1]})
    $display("icons done");
    wr(GPM_OFF_UPR_ADDR, 32'h0);
    for (int i = 0; i < 64; i++) begin
      upr[i] = 8'($urandom);
      wr(GPM_OFF_UPR_DATA, {24'h0, upr[i]});
    end
    for (int f = 0; f < 2; f++) begin
      wr(GPM_OFF_CTRL, 32'(f << 1));
      for (int n = 0; n < 24; n++) begin
        c = {4'h0, 4'($urandom)};
        l = (n == 0) ? 3'h7 : 3'($urandom);
        cu = (n == 0) ? 1'b1 : 1'($urandom);
        b = upr[{c[2:0], l}];
        v = f ? b[5:0] : {1'b0, b[4:0]};
        if (cu && l == 3'h7) v = f ? 6'h3f : 6'h1f;
        look(c, l, cu, v);
      end
    end
    for (int f = 0; f < 2; f++) begin
      wr(GPM_OFF_CTRL, 32'((f << 1) | 1));
      for (int n = 0; n < 16; n++) begin
        c = {4'h0, 4'($urandom)};
        l = 3'($urandom);
        look_blink(c, l, upr[{c[2:0], l}], 1'(f));
      end
    end
    wr(GPM_OFF_CTRL, 32'h0);
    for (int n = 0; n < 12; n++) begin
      c = 8'h10 + 8'($urandom % 240);
      l = 3'($urandom);
      b = 8'($urandom);
      wr(GPM_OFF_ROM_ADDR, {20'h0, c, 1'b0, l});
      wr(GPM_OFF_ROM_DATA, {24'h0, b});
      wr(GPM_OFF_ROM_ADDR, {20'h0, c, 1'b1, l});
      wr(GPM_OFF_ROM_DATA, {24'h0, ~b});
      look(c, l, 1'b0, {1'b0, b[4:0]});
    end
    $display("patterns done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
